// file: event_counter.sv
// Saturating event counter for software visibility of accepted events.
// Assumes inc is a one-cycle pulse; clear drops the old count but keeps a coincident inc.
`timescale 1ns/1ps
module event_counter
  import run_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             clear,
  input  wire logic             inc,
  // Count
  output logic      [CNT_W-1:0] count
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } cnt_state_type;

  cnt_state_type s_r;
  cnt_state_type s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Saturate rather than wrap, so a flood of events never reads as few
  always_comb
  begin
    s_nxt = s_r;
    if (clear)
    begin
      // An event landing in the clearing cycle still counts
      s_nxt.cnt = CNT_RST | {{(CNT_W-1){1'b0}}, inc};
    end
    else if (inc && (s_r.cnt != {CNT_W{1'b1}}))
    begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r <= '{cnt: CNT_RST};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.cnt;

endmodule // event_counter

// file: pin_event_detect.sv
// Two-flop synchroniser and edge detector for one trigger or restart pin.
// Assumes the pin may be fully asynchronous to clk; emits one pulse per assertion.
`timescale 1ns/1ps
module pin_event_detect
  import run_ctrl_pkg::*;
#(
  parameter bit ACTIVE_LOW = 1'b0
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin and event
  input  wire logic pin,
  output logic      event_pulse
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic pulse;
  } det_state_type;

  det_state_type s_r;
  det_state_type s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next state; meta is read only by the second stage
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.meta  = pin;
    s_nxt.sync  = s_r.meta;
    s_nxt.prev  = s_r.sync;
    // Edge only, so a long pulse acts once
    s_nxt.pulse = (s_r.sync ^ ACTIVE_LOW) & ~(s_r.prev ^ ACTIVE_LOW); // see [RULE19]
  end

  // Reset to the pulled-up or pulled-down idle level of the pin
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r <= '{meta: ACTIVE_LOW, sync: ACTIVE_LOW, prev: ACTIVE_LOW, pulse: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign event_pulse = s_r.pulse;

  // A held level never gives two pulses in a row
  a_pulse_once: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE19]
    event_pulse |=> !event_pulse)
    else $error("event pulse longer than one cycle");

endmodule // pin_event_detect

// file: pin_source_model.sv
// Far-side model: the trigger and restart signal sources on the input header.
// Assumes the bench pulses fire for one cycle; all pins share one length counter.
`timescale 1ns/1ps
module pin_source_model
(
  // Clock
  input  wire logic       clk,
  // Requests: b0 start_n, b1 high_a, b2 high_b, b3 restart_n, b4 restart_high
  input  wire logic [4:0] fire,
  input  wire logic [7:0] len,
  // Pins
  output logic            ext_start_in_n,
  output logic            ext_start_in_high_a,
  output logic            ext_start_in_high_b,
  output logic            ext_restart_in_n,
  output logic            ext_restart_in_high
);
  logic [4:0] act_r  = 5'h00;
  logic [7:0] left_r = 8'h00;

  // Pulse timer; several pins may fire together to model a collision
  always_ff @(posedge clk)
  begin
    if (|fire)
    begin
      act_r  <= fire;
      left_r <= len;
    end
    else if (left_r != 8'h00)
    begin
      left_r <= left_r - 8'h01;
      if (left_r == 8'h01)
        act_r <= 5'h00;
    end
  end

  // Released pins fall back to their pull levels: n pins up, high pins down
  assign ext_start_in_n      = ~act_r[0];
  assign ext_start_in_high_a = act_r[1];
  assign ext_start_in_high_b = act_r[2];
  assign ext_restart_in_n    = ~act_r[3];
  assign ext_restart_in_high = act_r[4];
endmodule // pin_source_model

// file: pulse_program_run_control.sv
// Run-state control of the pulse sequencer: status outputs, trigger and restart pins.
// Assumes the decode datapath reports halt and pause opcodes as one-cycle pulses
// and follows pc_clear and resume; software reaches it over a plain register port.
`timescale 1ns/1ps
module pulse_program_run_control
  import run_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // External trigger pins
  input  wire logic              ext_start_in_n,
  input  wire logic              ext_start_in_high_a,
  input  wire logic              ext_start_in_high_b,
  // External restart pins
  input  wire logic              ext_restart_in_n,
  input  wire logic              ext_restart_in_high,
  // From instruction decode
  input  wire logic              halt_exec,
  input  wire logic              pause_exec,
  // To instruction fetch
  output logic                   pc_clear,
  output logic                   resume,
  // Status outputs
  output logic                   reset_state_out,
  output logic                   running_out,
  output logic                   waiting_out,
  output logic                   stopped_out,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata
);

  typedef struct packed {
    run_state_type     st;
    logic              reset_out;
    logic              run_out;
    logic              wait_out;
    logic              stop_out;
    logic              pc_clr;
    logic              res;
    logic              trig_acc;
    logic              rst_acc;
    logic [DATA_W-1:0] rd;
  } ctrl_state_type;

  ctrl_state_type s_r;
  ctrl_state_type s_nxt;

  logic             trig_lo_ev;
  logic             trig_ha_ev;
  logic             trig_hb_ev;
  logic             rst_lo_ev;
  logic             rst_hi_ev;
  logic             hw_trig;
  logic             hw_restart;
  logic             ctrl_wr;
  logic             sw_start;
  logic             sw_restart;
  logic             sw_load;
  logic             sw_unload;
  logic             sw_clr_cnt;
  logic             any_restart;
  logic             any_start;
  logic [CNT_W-1:0] trig_cnt;
  logic [CNT_W-1:0] restart_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, one per pin
  pin_event_detect #(.ACTIVE_LOW(1'b1)) u_trig_lo ( // see [RULE7]
    .clk         (clk),
    .rst_n       (rst_n),
    .pin         (ext_start_in_n),
    .event_pulse (trig_lo_ev)
  );

  pin_event_detect #(.ACTIVE_LOW(1'b0)) u_trig_ha ( // see [RULE8]
    .clk         (clk),
    .rst_n       (rst_n),
    .pin         (ext_start_in_high_a),
    .event_pulse (trig_ha_ev)
  );

  pin_event_detect #(.ACTIVE_LOW(1'b0)) u_trig_hb ( // see [RULE8]
    .clk         (clk),
    .rst_n       (rst_n),
    .pin         (ext_start_in_high_b),
    .event_pulse (trig_hb_ev)
  );

  pin_event_detect #(.ACTIVE_LOW(1'b1)) u_rst_lo ( // see [RULE14]
    .clk         (clk),
    .rst_n       (rst_n),
    .pin         (ext_restart_in_n),
    .event_pulse (rst_lo_ev)
  );

  pin_event_detect #(.ACTIVE_LOW(1'b0)) u_rst_hi ( // see [RULE14]
    .clk         (clk),
    .rst_n       (rst_n),
    .pin         (ext_restart_in_high),
    .event_pulse (rst_hi_ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event merge; all pins of a kind are interchangeable
  assign hw_trig     = trig_lo_ev | trig_ha_ev | trig_hb_ev; // see [RULE6]
  assign hw_restart  = rst_lo_ev | rst_hi_ev;                // see [RULE13]
  assign ctrl_wr     = wr_en && (addr == CTRL_OFS);
  assign sw_start    = ctrl_wr && wdata[CTRL_START_BIT];
  assign sw_restart  = ctrl_wr && wdata[CTRL_RESTART_BIT];
  assign sw_load     = ctrl_wr && wdata[CTRL_LOAD_BIT];
  assign sw_unload   = ctrl_wr && wdata[CTRL_UNLOAD_BIT];
  assign sw_clr_cnt  = ctrl_wr && wdata[CTRL_CLR_CNT_BIT];
  assign any_restart = hw_restart | sw_restart;
  assign any_start   = hw_trig | sw_start;

  ////////////////////////////////////////////////////////////////////////////
  // Run-state machine and registered outputs
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.pc_clr   = 1'b0;
    s_nxt.res      = 1'b0;
    s_nxt.trig_acc = 1'b0;
    s_nxt.rst_acc  = 1'b0;
    if (sw_unload)
    begin
      // Program memory released: must be loaded again before any run
      s_nxt.st = ST_RESET;
    end
    else
    begin
      case (s_r.st)
        ST_RESET:
        begin
          if (sw_load)
          begin
            s_nxt.st     = ST_IDLE;
            s_nxt.pc_clr = 1'b1;
          end
        end
        ST_IDLE:
        begin
          // Restart checked first so a coincident trigger is dropped
          if (any_restart)
          begin
            s_nxt.pc_clr  = 1'b1; // see [RULE20]
            s_nxt.rst_acc = 1'b1;
          end
          else if (any_start)
          begin
            s_nxt.st       = ST_RUN;   // see [RULE9] [RULE16] [RULE17]
            s_nxt.pc_clr   = 1'b1;     // see [RULE9]
            s_nxt.trig_acc = hw_trig;
          end
        end
        ST_RUN:
        begin
          if (any_restart)
          begin
            s_nxt.st      = ST_IDLE;   // see [RULE10] [RULE15]
            s_nxt.pc_clr  = 1'b1;      // see [RULE15]
            s_nxt.rst_acc = 1'b1;
          end
          else if (halt_exec)
          begin
            s_nxt.st = ST_STOPPED;     // see [RULE10] [RULE18]
          end
          else if (pause_exec)
          begin
            s_nxt.st = ST_PAUSE;       // see [RULE4]
          end
        end
        ST_PAUSE:
        begin
          if (any_restart)
          begin
            s_nxt.st      = ST_IDLE;   // see [RULE15] [RULE20]
            s_nxt.pc_clr  = 1'b1;
            s_nxt.rst_acc = 1'b1;
          end
          else if (any_start)
          begin
            s_nxt.st       = ST_RUN;   // see [RULE12]
            s_nxt.res      = 1'b1;     // see [RULE12]
            s_nxt.trig_acc = hw_trig;
          end
        end
        ST_STOPPED:
        begin
          // Triggers are ignored until a restart re-arms the program
          if (any_restart)
          begin
            s_nxt.st      = ST_IDLE;   // see [RULE11]
            s_nxt.pc_clr  = 1'b1;
            s_nxt.rst_acc = 1'b1;
          end
        end
        default:
        begin
          s_nxt.st = ST_RESET;
        end
      endcase
    end
    // Outputs decoded from the next state so they change with it
    s_nxt.reset_out = (s_nxt.st == ST_RESET);     // see [RULE1]
    s_nxt.run_out   = is_running(s_nxt.st);       // see [RULE2] [RULE3] [RULE5]
    s_nxt.wait_out  = (s_nxt.st == ST_PAUSE);     // see [RULE4]
    s_nxt.stop_out  = (s_nxt.st == ST_STOPPED);   // see [RULE18]
    // Read data valid in the cycle after the strobe only
    s_nxt.rd = RDATA_RST;
    if (rd_en)
    begin
      if (addr == STATUS_OFS)
      begin
        s_nxt.rd[STAT_RESET_BIT]   = s_r.reset_out;
        s_nxt.rd[STAT_RUNNING_BIT] = s_r.run_out;
        s_nxt.rd[STAT_WAITING_BIT] = s_r.wait_out;
        s_nxt.rd[STAT_STOPPED_BIT] = s_r.stop_out;
        s_nxt.rd[STAT_IDLE_BIT]    = (s_r.st == ST_IDLE);
      end
      else if (addr == TRIG_CNT_OFS)
      begin
        s_nxt.rd[CNT_W-1:0] = trig_cnt;
      end
      else if (addr == RESTART_CNT_OFS)
      begin
        s_nxt.rd[CNT_W-1:0] = restart_cnt;
      end
    end
  end

  // Synchronous reset leaves the block with no program loaded
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r <= '{st: ST_RESET, reset_out: 1'b1, run_out: 1'b0, wait_out: 1'b0,
               stop_out: 1'b0, pc_clr: 1'b0, res: 1'b0, trig_acc: 1'b0,
               rst_acc: 1'b0, rd: RDATA_RST};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accepted-event counters for software
  event_counter u_trig_cnt (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (sw_clr_cnt),
    .inc   (s_r.trig_acc),
    .count (trig_cnt)
  );

  event_counter u_restart_cnt (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (sw_clr_cnt),
    .inc   (s_r.rst_acc),
    .count (restart_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Port drive, all straight from flops
  assign pc_clear        = s_r.pc_clr;
  assign resume          = s_r.res;
  assign reset_state_out = s_r.reset_out;
  assign running_out     = s_r.run_out;
  assign waiting_out     = s_r.wait_out;
  assign stopped_out     = s_r.stop_out;
  assign rdata           = s_r.rd;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_flag: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE1]
    reset_state_out == (s_r.st == ST_RESET))
    else $error("reset-state output disagrees with state");

  a_running_flag: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE2]
    (s_r.st == ST_RUN) |-> running_out)
    else $error("running low while executing");

  a_running_low: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE3]
    ((s_r.st == ST_IDLE) || (s_r.st == ST_RESET)) |-> !running_out)
    else $error("running high in idle or reset");

  a_pause_entry: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE4]
    ((s_r.st == ST_RUN) && pause_exec && !any_restart && !halt_exec && !sw_unload)
      |=> waiting_out && running_out)
    else $error("pause opcode did not raise waiting");

  a_pause_both: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE5]
    waiting_out |-> running_out)
    else $error("waiting without running");

  a_idle_start: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE9]
    ((s_r.st == ST_IDLE) && hw_trig && !any_restart && !sw_unload)
      |=> pc_clear && running_out ##1 !pc_clear)
    else $error("trigger in idle did not start from first instruction");

  a_halt_stop: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE18]
    ((s_r.st == ST_RUN) && halt_exec && !any_restart && !sw_unload)
      |=> stopped_out && !running_out)
    else $error("halt opcode did not stop");

  a_pause_resume: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE12]
    ((s_r.st == ST_PAUSE) && any_start && !any_restart && !sw_unload)
      |=> resume && !pc_clear && !waiting_out)
    else $error("trigger in pause did not resume");

  a_restart_run: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE15]
    (is_running(s_r.st) && any_restart && !sw_unload)
      |=> pc_clear && !running_out && (s_r.st == ST_IDLE))
    else $error("restart did not return to first instruction");

  a_restart_wins: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE20]
    ((s_r.st == ST_IDLE) && hw_restart && hw_trig && !sw_unload)
      |=> !running_out)
    else $error("trigger beat a coincident restart");

  // The pin edge reaches the state machine three edges after it is first sampled,
  // so running shows on the fourth edge
  a_pin_trigger: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE17]
    ((s_r.st == ST_IDLE) && $fell(ext_start_in_n) && !ext_restart_in_high
      && ext_restart_in_n && !wr_en) ##1 (s_r.st == ST_IDLE && !wr_en
      && ext_restart_in_n && !ext_restart_in_high)[*3]
      |=> running_out)
    else $error("low trigger pin edge not acted on");

  a_stopped_hold: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE11]
    ((s_r.st == ST_STOPPED) && !any_restart && !sw_unload) |=> stopped_out)
    else $error("stopped state left without restart");

  a_unload_reset: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE1]
    sw_unload |=> reset_state_out && !running_out)
    else $error("unload did not return to reset state");

endmodule // pulse_program_run_control

// file: pulse_program_run_control_tb.sv
// Self-checking bench for the run control: pins, decode strobes, register port.
// Assumes the hand-over latencies: pin to state in 3 edges, strobes act next edge.
`timescale 1ns/1ps
module pulse_program_run_control_tb;
  import run_ctrl_pkg::*;

  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [4:0]        fire = 5'h00;
  logic [7:0]        len = 8'h00;
  logic              s_n, s_a, s_b, r_n, r_h;
  logic              halt_exec = 1'b0;
  logic              pause_exec = 1'b0;
  logic              pc_clear, resume;
  logic              reset_state_out, running_out, waiting_out, stopped_out;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 32'h0000_0000;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rd_val;
  logic [31:0]       pc_cnt = 32'h0;
  logic [31:0]       rs_cnt = 32'h0;
  logic [31:0]       p0, r0;
  int                fail_count = 0;
  int                checks = 0;
  int                cyc = 0;

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  pin_source_model src (.clk(clk), .fire(fire), .len(len), .ext_start_in_n(s_n),
    .ext_start_in_high_a(s_a), .ext_start_in_high_b(s_b), .ext_restart_in_n(r_n),
    .ext_restart_in_high(r_h));

  pulse_program_run_control dut (.clk(clk), .rst_n(rst_n), .ext_start_in_n(s_n),
    .ext_start_in_high_a(s_a), .ext_start_in_high_b(s_b), .ext_restart_in_n(r_n),
    .ext_restart_in_high(r_h), .halt_exec(halt_exec), .pause_exec(pause_exec),
    .pc_clear(pc_clear), .resume(resume), .reset_state_out(reset_state_out),
    .running_out(running_out), .waiting_out(waiting_out), .stopped_out(stopped_out),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Pulse tallies; each pin pulse gives at most one of these
  always @(posedge clk)
  begin
    if (pc_clear === 1'b1) pc_cnt <= pc_cnt + 32'h1;
    if (resume === 1'b1) rs_cnt <= rs_cnt + 32'h1;
  end

  // Hang guard, far above the roughly 210 cycles the tests need
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks = checks + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Status pins as {stopped, waiting, running, reset}
  task automatic st(input logic [3:0] e);
    chk({28'h0, stopped_out, waiting_out, running_out, reset_state_out}, {28'h0, e},
      "status pins");
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    rd_val = rdata;
  endtask

  task automatic pin(input logic [4:0] m, input logic [7:0] l);
    @(posedge clk);
    fire <= m;
    len  <= l;
    @(posedge clk);
    fire <= 5'h00;
    repeat (l + 6) @(posedge clk);
    #1;
  endtask

  task automatic dec(input logic h, input logic p);
    @(posedge clk);
    halt_exec  <= h;
    pause_exec <= p;
    @(posedge clk);
    halt_exec  <= 1'b0;
    pause_exec <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    st(4'b0001);
    rd(STATUS_OFS);
    chk(rd_val, 32'h1, "status after reset");
    rd(4'h2);
    chk(rd_val, 32'h0, "unmapped read");
    pin(5'h01, 8'h03);
    st(4'b0001);
    pin(5'h08, 8'h03);
    st(4'b0001);
    $display("test reset state done");

    wr(CTRL_OFS, 32'h4);
    st(4'b0000);
    rd(STATUS_OFS);
    chk(rd_val, 32'h10, "status idle");
    for (int i = 0; i < 3; i++)
    begin
      p0 = pc_cnt;
      pin(5'h01 << i, 8'h02);
      st(4'b0010);
      chk(pc_cnt - p0, 32'h1, "start from first");
      pin((i == 1) ? 5'h10 : 5'h08, 8'h02);
      st(4'b0000);
      chk(pc_cnt - p0, 32'h2, "restart to first");
    end
    $display("test trigger and restart pins done");

    p0 = pc_cnt;
    pin(5'h01, 8'h14);
    chk(pc_cnt - p0, 32'h1, "long pulse once");
    st(4'b0010);
    dec(1'b0, 1'b1);
    st(4'b0110);
    rd(STATUS_OFS);
    chk(rd_val, 32'h6, "paused status");
    r0 = rs_cnt;
    p0 = pc_cnt;
    pin(5'h02, 8'h02);
    st(4'b0010);
    chk(rs_cnt - r0, 32'h1, "resume pulse");
    chk(pc_cnt - p0, 32'h0, "no rewind on resume");
    $display("test pause and resume done");

    dec(1'b1, 1'b0);
    st(4'b1000);
    pin(5'h04, 8'h02);
    st(4'b1000);
    pin(5'h08, 8'h02);
    st(4'b0000);
    // Collision while idle, where a winning trigger would start a run
    pin(5'h11, 8'h02);
    st(4'b0000);
    wr(CTRL_OFS, 32'h1);
    st(4'b0010);
    wr(CTRL_OFS, 32'h2);
    st(4'b0000);
    wr(CTRL_OFS, 32'h8);
    st(4'b0001);
    $display("test halt and collision done");

    rd(TRIG_CNT_OFS);
    chk(rd_val, 32'h5, "trigger count");
    rd(RESTART_CNT_OFS);
    chk(rd_val, 32'h6, "restart count");
    wr(CTRL_OFS, 32'h10);
    rd(TRIG_CNT_OFS);
    chk(rd_val, 32'h0, "trigger count cleared");
    rd(RESTART_CNT_OFS);
    chk(rd_val, 32'h0, "restart count cleared");
    $display("test counters done");
    summarize();
  end
endmodule // pulse_program_run_control_tb

// file: run_ctrl_pkg.sv
// Constants, types and helpers shared by the pulse-program run control.
// Assumes one 50 MHz core clock and a synchronous active-low reset.
// Notes on behaviour
// [RULE1] Reset-state output is high while no program is loaded.
// [RULE2] Running output is high while a loaded program executes.
// [RULE3] Running output is low in the reset state and the idle state.
// [RULE4] Waiting output is high after a pause opcode until the resume trigger.
// [RULE5] Running stays high during pause, together with waiting.
// [RULE6] The active-low trigger pin and both active-high trigger pins are the same event.
// [RULE7] A low pulse on the active-low trigger pin is a trigger.
// [RULE8] A high pulse on either active-high trigger pin is a trigger.
// [RULE9] A trigger while idle starts the program from its first instruction.
// [RULE10] Idle is entered on a halt opcode or on a hardware restart; here a halt opcode enters the stopped state instead.
// [RULE11] After a halt the far side must restart before triggering.
// [RULE12] A trigger while paused resumes at the instruction after the pause.
// [RULE13] The active-low and active-high restart pins are the same event.
// [RULE14] Low pulse on the low pin, high pulse on the high pin, both restart.
// [RULE15] A restart during execution stops and returns position to the first instruction.
// [RULE16] After a restart, a software start or a trigger resumes execution.
// [RULE17] Trigger acts on the falling edge of the low pin, and only when idle; here a trigger also resumes from the paused state.
// [RULE18] Stopped output is high after a halt opcode put the program in stopped state.
// [RULE19] Inputs are synchronised; each pulse acts once, however long it lasts.
// [RULE20] Trigger and restart in the same cycle: restart wins, trigger is ignored.
package run_ctrl_pkg;

  // Register bus geometry
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  localparam int          CNT_W           = 16;

  // Register offsets (byte addresses)
  localparam logic [3:0]  CTRL_OFS        = 4'h0;
  localparam logic [3:0]  STATUS_OFS      = 4'h4;
  localparam logic [3:0]  TRIG_CNT_OFS    = 4'h8;
  localparam logic [3:0]  RESTART_CNT_OFS = 4'hc;

  // Control word bits, all self-clearing commands
  localparam int          CTRL_START_BIT   = 0;
  localparam int          CTRL_RESTART_BIT = 1;
  localparam int          CTRL_LOAD_BIT    = 2;
  localparam int          CTRL_UNLOAD_BIT  = 3;
  localparam int          CTRL_CLR_CNT_BIT = 4;

  // Status word bits
  localparam int          STAT_RESET_BIT   = 0;
  localparam int          STAT_RUNNING_BIT = 1;
  localparam int          STAT_WAITING_BIT = 2;
  localparam int          STAT_STOPPED_BIT = 3;
  localparam int          STAT_IDLE_BIT    = 4;

  // Reset values
  localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // Cycles from a pin change (sampled at edge k) to running being sampled high
  localparam int          PIN_TO_STATE     = 4;

  // Run states, one-hot
  typedef enum logic [4:0] {
    ST_RESET   = 5'b00001,
    ST_IDLE    = 5'b00010,
    ST_RUN     = 5'b00100,
    ST_PAUSE   = 5'b01000,
    ST_STOPPED = 5'b10000
  } run_state_type;

  // Running covers both executing and paused
  function automatic logic is_running(input run_state_type st);
    return (st == ST_RUN) || (st == ST_PAUSE);
  endfunction

  // Restart may only act where there is a loaded program
  function automatic logic is_loaded(input run_state_type st);
    return st != ST_RESET;
  endfunction

endpackage
